// [bench/pcsb_pin_host.sv]
`timescale 1ns/1ps
// ***********************************************
// Host logic driving the three setting pins
// ***********************************************
module pcsb_pin_host (
   input wire logic [2:0] setting_idx,
   output logic setting_pin_a,
   output logic setting_pin_b,
   output logic setting_pin_c
);
   // Static levels; the host only moves them between checks, never mid-check
   assign setting_pin_a = setting_idx[0];
   assign setting_pin_b = setting_idx[1];
   assign setting_pin_c = setting_idx[2];
endmodule : pcsb_pin_host

// [bench/tb_top.sv]
`timescale 1ns/1ps
module tb_top import pcsb_pkg::*;;
   // ***********************************************
   // Stimulus and observed signals
   // ***********************************************
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [2:0] sel_idx = 3'h0;
   logic pin_a, pin_b, pin_c;
   logic [31:0] prdata, rd;
   logic pready, pslverr, er;
   logic [2:0] active_setting, spread_amount;
   logic [3:0] spread_quarter_pct;
   logic spread_mod_on, spread_center, freq_set_b, loop_bypass, loop_power_down;
   logic first_output_source, pair_oe, pair_force_low, divider_four_run, divider_five_run;
   logic [1:0] second_output_source;
   logic [6:0] divider_four_value, divider_five_value;
   int err_count = 0;
   int compares = 0;

   always #12.5 pclk = ~pclk;

   pcsb_pin_host host (.setting_idx(sel_idx), .setting_pin_a(pin_a),
      .setting_pin_b(pin_b), .setting_pin_c(pin_c));

   pcsb_bank DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .setting_pin_a(pin_a), .setting_pin_b(pin_b),
      .setting_pin_c(pin_c), .active_setting(active_setting), .spread_amount(spread_amount),
      .spread_quarter_pct(spread_quarter_pct), .spread_mod_on(spread_mod_on),
      .spread_center(spread_center), .freq_set_b(freq_set_b), .loop_bypass(loop_bypass),
      .loop_power_down(loop_power_down), .first_output_source(first_output_source),
      .second_output_source(second_output_source), .pair_oe(pair_oe),
      .pair_force_low(pair_force_low), .divider_four_value(divider_four_value),
      .divider_four_run(divider_four_run), .divider_five_value(divider_five_value),
      .divider_five_run(divider_five_run));

   // ***********************************************
   // Shared tasks
   // ***********************************************
   task report_and_stop;
      $display("Counts: compares=%0d mismatches=%0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : report_and_stop

   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer; answer taken at the rising edge that completes the access
   // and only then released; a slave that never answers is left to the watchdog
   task apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task rdchk(input logic [9:0] idx, input logic [7:0] exp, input logic e);
      apb(1'b0, idx, 8'h00);
      chk(rd, {24'h0, exp});
      chk(er, e);
   endtask : rdchk

   // A pin change reaches the outputs on the sixth edge: sync, filter, index, decode
   task pick(input logic [2:0] s);
      @(posedge pclk);
      sel_idx <= s;
      repeat (6) @(posedge pclk);
      @(negedge pclk);
   endtask : pick

   task settle;
      repeat (2) @(negedge pclk);
   endtask : settle

   // ***********************************************
   // Scenarios
   // ***********************************************
   task t_reset;
      chk(loop_bypass, 1);
      chk(loop_power_down, 1);
      chk(first_output_source, 1);
      chk(second_output_source, 2'b10);
      chk(pair_oe, 0);
      chk(spread_mod_on, 0);
      chk(spread_center, 0);
      chk(freq_set_b, 0);
      chk(divider_five_run, 1);
      for (int i = 0; i < 3; i++) rdchk(PCSB_IDX_SPREAD_UPPER + i, 8'h00, 0);
      rdchk(PCSB_IDX_FREQ_SET, 8'h00, 0);
      rdchk(PCSB_IDX_ROUTING, 8'hed, 0);
      rdchk(PCSB_IDX_STATE_SEL, 8'h02, 0);
      rdchk(PCSB_IDX_DIR_DIV_FOUR, 8'h01, 0);
      rdchk(PCSB_IDX_DIV_FIVE, 8'h01, 0);
      pick(3'h1);
      chk(pair_oe, 1);
      $display("test reset done");
   endtask : t_reset

   task t_unmapped;
      apb(1'b1, 10'h028, 8'h5a);
      chk(er, 1);
      rdchk(10'h028, 8'h00, 1);
      rdchk(10'h01f, 8'h00, 1);
      rdchk(PCSB_IDX_SPREAD_UPPER, 8'h00, 0);
      $display("test unmapped done");
   endtask : t_unmapped

   // Every setting gets its own spread code, so a wrong field slice shows up
   task t_sweep;
      logic [23:0] w;
      for (int s = 0; s < 8; s++) w[3*s +: 3] = s[2:0];
      apb(1'b1, PCSB_IDX_SPREAD_UPPER, w[23:16]);
      apb(1'b1, PCSB_IDX_SPREAD_MIDDLE, w[15:8]);
      apb(1'b1, PCSB_IDX_SPREAD_LOWER, w[7:0]);
      apb(1'b1, PCSB_IDX_FREQ_SET, 8'ha5);
      apb(1'b1, PCSB_IDX_STATE_SEL, 8'h3c);
      apb(1'b1, PCSB_IDX_ROUTING, 8'h1b);
      rdchk(PCSB_IDX_SPREAD_MIDDLE, w[15:8], 0);
      for (int s = 0; s < 8; s++) begin
         pick(s[2:0]);
         chk(active_setting, s);
         chk(spread_amount, s);
         chk(spread_mod_on, s != 0);
         chk(spread_quarter_pct, (s == 7) ? 8 : s);
         chk(freq_set_b, (8'ha5 >> s) & 1);
         chk(pair_force_low, (8'h3c >> s) & 1);
         chk(pair_oe, 1);
         chk(loop_power_down, 0);
      end
      chk(loop_bypass, 0);
      chk(first_output_source, 0);
      chk(second_output_source, 2'b01);
      $display("test sweep done");
   endtask : t_sweep

   task t_states;
      apb(1'b1, PCSB_IDX_ROUTING, 8'h64);
      pick(3'h0);
      chk(pair_oe, 0);
      chk(loop_power_down, 1);
      pick(3'h2);
      chk(pair_oe, 0);
      chk(loop_power_down, 0);
      apb(1'b1, PCSB_IDX_ROUTING, 8'he4);
      settle();
      chk(loop_bypass, 1);
      chk(loop_power_down, 1);
      $display("test states done");
   endtask : t_states

   task t_divider;
      apb(1'b1, PCSB_IDX_DIR_DIV_FOUR, 8'h85);
      apb(1'b1, PCSB_IDX_DIV_FIVE, 8'hff);
      settle();
      chk(spread_center, 1);
      chk(divider_four_value, 7'h05);
      chk(divider_five_value, 7'h7f);
      chk(divider_four_run, 1);
      rdchk(PCSB_IDX_DIV_FIVE, 8'h7f, 0);
      apb(1'b1, PCSB_IDX_DIR_DIV_FOUR, 8'h00);
      apb(1'b1, PCSB_IDX_DIV_FIVE, 8'h00);
      settle();
      chk(spread_center, 0);
      chk(divider_four_run, 0);
      chk(divider_five_run, 0);
      $display("test divider done");
   endtask : t_divider

   // Reset in mid-run must bring back the power-up contents
   task t_rerun;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      settle();
      chk(spread_amount, 0);
      chk(loop_bypass, 1);
      rdchk(PCSB_IDX_SPREAD_LOWER, 8'h00, 0);
      rdchk(PCSB_IDX_ROUTING, 8'hed, 0);
      $display("test rerun done");
   endtask : t_rerun

   // ***********************************************
   // Main sequence and watchdog
   // ***********************************************
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      settle();
      t_reset();
      t_unmapped();
      t_sweep();
      t_states();
      t_divider();
      t_rerun();
      report_and_stop();
   end

   // Whole run needs well under a thousand cycles; this cuts a hang short
   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      report_and_stop();
   end
endmodule : tb_top

// [logic/pcsb_bank.sv]
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
//
// Contract
// RULE_01: Eight 3-bit spread amounts, reset zero, selected setting's amount applied.
// RULE_02: Spread code 000 is off; 001 is 0.25%, 100 is 1.0%.
// RULE_03: Spread direction bit: 0 downward, 1 center, reset downward.
// RULE_04: Eight frequency-set bits in one byte, reset zero, selected bit picks config.
// RULE_05: Frequency-set bit 0 runs the loop from configuration set a.
// RULE_06: Frequency-set bit 1 runs the loop from configuration set b.
// RULE_07: Bypass bit 0 routes loop; 1 routes bypass, powers loop down; reset 1.
// RULE_08: First output source bit chooses between two dividers, reset 1.
// RULE_09: Software writes second source only with defined codes, reset 10.
// RULE_10: Two state definitions, reset 11 and 01; tri-state with or without power down.
// RULE_11: State code 10 drives both outputs low; 11 lets them toggle.
// RULE_12: Eight state-select bits in one byte choose between the two definitions.
// RULE_13: State-select bit 0 applies definition a.
// RULE_14: State-select bit 1 applies definition b; only setting 1 set at reset.
// RULE_15: Eight settings; active one picked from three select pins.
// RULE_16: Active index is binary with pin c as MSB, pin a as LSB.
// RULE_17: Register data is ordered most-significant bit first.
// RULE_18: Software does not write beyond the top register address.
// RULE_19: Divider value 0 holds divider in standby; 1 to 127 set ratio.
//
module pcsb_bank import pcsb_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic setting_pin_a,
   input wire logic setting_pin_b,
   input wire logic setting_pin_c,
   output logic [2:0] active_setting,
   output logic [2:0] spread_amount,
   output logic [3:0] spread_quarter_pct,
   output logic spread_mod_on,
   output logic spread_center,
   output logic freq_set_b,
   output logic loop_bypass,
   output logic loop_power_down,
   output logic first_output_source,
   output logic [1:0] second_output_source,
   output logic pair_oe,
   output logic pair_force_low,
   output logic [6:0] divider_four_value,
   output logic divider_four_run,
   output logic [6:0] divider_five_value,
   output logic divider_five_run
);
   // ***********************************************************
   // Helpers
   // ***********************************************************
   // Spread amount in quarter percent; top code jumps to 2.0%
   function automatic logic [3:0] spread_quarters(input logic [2:0] code);
      logic [3:0] q;
      q = {1'b0, code};
      if (code == 3'h7) begin
         q = 4'h8;
      end
      return q;
   endfunction : spread_quarters

   // True for the eight words of this bank; anything else is refused
   function automatic logic is_mapped(input logic [9:0] idx);
      return (idx >= PCSB_IDX_SPREAD_UPPER) && (idx <= PCSB_IDX_DIV_FIVE);
   endfunction : is_mapped

   // ***********************************************************
   // Setting select pins
   // ***********************************************************
   logic [2:0] pins_lvl;

   // Pins are asynchronous to pclk, so they are filtered before any decode sees them
   pcsb_pin_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin_in({setting_pin_c, setting_pin_b, setting_pin_a}), // [RULE_16] [RULE_15]
      .level_out(pins_lvl)
   );

   // ***********************************************************
   // APB slave
   // ***********************************************************
   // Bank storage, one byte per word; upper write data bits are not kept
   logic [7:0] regs_q [PCSB_NUM_REGS];
   logic [7:0] regs_d [PCSB_NUM_REGS];
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d, pslverr_q, pslverr_d;
   pcsb_bus_type bus_q, bus_d;
   logic [9:0] word_idx;
   logic [2:0] slot;
   logic wr_take;

   // Low two address bits are ignored; each register takes one aligned word
   assign word_idx = paddr[11:2];
   assign slot = word_idx[2:0];
   assign wr_take = psel && penable && pready_q && pwrite && !pslverr_q;

   // Answer one cycle after setup: zero wait states, data decoded at setup
   always_comb begin
      bus_d = bus_q;
      pready_d = 1'b0;
      pslverr_d = pslverr_q;
      prdata_d = prdata_q;
      case (bus_q)
         PCSB_IDLE: begin
            if (psel && !penable) begin
               bus_d = PCSB_ACCESS;
               pready_d = 1'b1;
               pslverr_d = !is_mapped(word_idx); // [RULE_18]
               prdata_d = 32'h0;
               if (is_mapped(word_idx) && !pwrite) begin
                  prdata_d = {24'h0, regs_q[slot]}; // [RULE_17]
               end
            end
         end
         PCSB_ACCESS: begin
            bus_d = PCSB_IDLE;
            pslverr_d = 1'b0;
         end
         default: begin
            bus_d = PCSB_IDLE;
         end
      endcase
   end

   // Register writes land at the completing access edge only
   always_comb begin
      for (int i = 0; i < PCSB_NUM_REGS; i++) begin
         regs_d[i] = regs_q[i];
      end
      if (wr_take) begin
         regs_d[slot] = pwdata[7:0]; // [RULE_17]
         // Reserved top bit of divider five reads back zero
         if (word_idx == PCSB_IDX_DIV_FIVE) begin
            regs_d[slot] = pwdata[7:0] & PCSB_DIV_MASK;
         end
      end
   end

   // Bus and bank state; reset loads the power-up register contents
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_q <= PCSB_IDLE;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
         regs_q[0] <= PCSB_RST_SPREAD; // [RULE_01]
         regs_q[1] <= PCSB_RST_SPREAD;
         regs_q[2] <= PCSB_RST_SPREAD;
         regs_q[3] <= PCSB_RST_FREQ_SET; // [RULE_04]
         regs_q[4] <= PCSB_RST_ROUTING; // [RULE_07] [RULE_08] [RULE_10]
         regs_q[5] <= PCSB_RST_STATE_SEL; // [RULE_14]
         regs_q[6] <= PCSB_RST_DIR_DIV_FOUR; // [RULE_03]
         regs_q[7] <= PCSB_RST_DIV_FIVE;
      end else begin
         bus_q <= bus_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q <= prdata_d;
         for (int i = 0; i < PCSB_NUM_REGS; i++) begin
            regs_q[i] <= regs_d[i];
         end
      end
   end

   // Bus outputs come straight from their flip-flops
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;

   // ***********************************************************
   // Setting decode and applied controls
   // ***********************************************************
   logic [23:0] spread_all;
   logic [1:0] def_a, def_b, pair_code;
   logic [2:0] act_q, act_d, amt_q, amt_d;
   logic [3:0] pct_q, pct_d;
   logic mod_q, mod_d, ctr_q, ctr_d, fsb_q, fsb_d, byp_q, byp_d, pd_q, pd_d;
   logic src1_q, src1_d, oe_q, oe_d, low_q, low_d, run4_q, run4_d, run5_q, run5_d;
   logic [1:0] src2_q, src2_d;
   logic [6:0] div4_q, div4_d, div5_q, div5_d;

   // Setting 7 sits in the top bits of the upper register
   assign spread_all = {regs_q[0], regs_q[1], regs_q[2]};
   assign def_b = regs_q[4][PCSB_POS_STATE_DEF_B +: 2];
   assign def_a = regs_q[4][PCSB_POS_STATE_DEF_A +: 2];

   // Index one register stage after the pin level, controls one stage after the index; settings change cleanly per clock
   always_comb begin
      act_d = pins_lvl; // [RULE_15]
      amt_d = spread_all[act_q * 3 +: 3]; // [RULE_01]
      mod_d = (amt_d != PCSB_SPREAD_OFF); // [RULE_02]
      pct_d = spread_quarters(amt_d); // [RULE_02]
      ctr_d = regs_q[6][PCSB_POS_DIRECTION]; // [RULE_03]
      fsb_d = regs_q[3][act_q]; // [RULE_04] [RULE_05] [RULE_06]
      byp_d = regs_q[4][PCSB_POS_BYPASS]; // [RULE_07]
      src1_d = regs_q[4][PCSB_POS_FIRST_SRC]; // [RULE_08]
      // Reserved second source code is passed on unchanged; software avoids it
      src2_d = regs_q[4][PCSB_POS_SECOND_SRC +: 2];
      pair_code = regs_q[5][act_q] ? def_b : def_a; // [RULE_12] [RULE_13] [RULE_14]
      oe_d = (pair_code == PCSB_STATE_LOW) || (pair_code == PCSB_STATE_RUN); // [RULE_11]
      low_d = (pair_code == PCSB_STATE_LOW); // [RULE_11]
      pd_d = byp_d || (pair_code == PCSB_STATE_TRI_PD); // [RULE_07] [RULE_10]
      div4_d = regs_q[6][6:0];
      div5_d = regs_q[7][6:0];
      run4_d = (div4_d != PCSB_DIV_STANDBY); // [RULE_19]
      run5_d = (div5_d != PCSB_DIV_STANDBY); // [RULE_19]
   end

   // Reset values mirror the decode of the power-up register contents at setting 0
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_q <= 3'h0;
         amt_q <= 3'h0;
         pct_q <= 4'h0;
         mod_q <= 1'b0;
         ctr_q <= 1'b0;
         fsb_q <= 1'b0;
         byp_q <= 1'b1;
         pd_q <= 1'b1;
         src1_q <= 1'b1;
         src2_q <= 2'h2;
         oe_q <= 1'b0;
         low_q <= 1'b0;
         div4_q <= 7'h01;
         div5_q <= 7'h01;
         run4_q <= 1'b1;
         run5_q <= 1'b1;
      end else begin
         act_q <= act_d;
         amt_q <= amt_d;
         pct_q <= pct_d;
         mod_q <= mod_d;
         ctr_q <= ctr_d;
         fsb_q <= fsb_d;
         byp_q <= byp_d;
         pd_q <= pd_d;
         src1_q <= src1_d;
         src2_q <= src2_d;
         oe_q <= oe_d;
         low_q <= low_d;
         div4_q <= div4_d;
         div5_q <= div5_d;
         run4_q <= run4_d;
         run5_q <= run5_d;
      end
   end

   // Every applied control leaves the block from a flip-flop
   assign active_setting = act_q;
   assign spread_amount = amt_q;
   assign spread_quarter_pct = pct_q;
   assign spread_mod_on = mod_q;
   assign spread_center = ctr_q;
   assign freq_set_b = fsb_q;
   assign loop_bypass = byp_q;
   assign loop_power_down = pd_q;
   assign first_output_source = src1_q;
   assign second_output_source = src2_q;
   assign pair_oe = oe_q;
   assign pair_force_low = low_q;
   assign divider_four_value = div4_q;
   assign divider_four_run = run4_q;
   assign divider_five_value = div5_q;
   assign divider_five_run = run5_q;

   // ***********************************************************
   // Assertions
   // ***********************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_spread_follow: assert property (##1 amt_q == $past(spread_all[act_q * 3 +: 3])) // [RULE_01]
      else $error("spread amount not taken from active setting");
   a_spread_off: assert property ((mod_q == (amt_q != PCSB_SPREAD_OFF)) // [RULE_02]
      && (amt_q != 3'h1 || pct_q == 4'h1) && (amt_q != 3'h4 || pct_q == 4'h4))
      else $error("spread code decode wrong");
   a_direction: assert property (##1 ctr_q == $past(regs_q[6][7])) // [RULE_03]
      else $error("spread direction not applied");
   a_freq_set: assert property (##1 fsb_q == $past(regs_q[3][act_q])) // [RULE_04]
      else $error("frequency set bit not applied");
   a_bypass_pd: assert property (byp_q |-> pd_q) // [RULE_07]
      else $error("bypass without loop power down");
   a_state_low: assert property (low_q |-> oe_q) // [RULE_11]
      else $error("forced low without drive");
   a_state_sel: assert property (!regs_q[5][act_q] && !def_a[1] |=> !oe_q) // [RULE_13]
      else $error("definition a not applied");
   a_pin_index: assert property ($changed(pins_lvl) |=> act_q == $past(pins_lvl)) // [RULE_16]
      else $error("active setting not from pins");
   a_div_standby: assert property (run4_q == (div4_q != 7'h00)) // [RULE_19]
      else $error("divider standby flag wrong");
   a_unmapped_err: assert property (psel && !penable && !is_mapped(word_idx) // [RULE_18]
      |=> pready_q && pslverr_q)
      else $error("unmapped access not flagged");


   // Output pair: every state code has exactly one drive pattern
   a_state_run: assert property (pair_code == PCSB_STATE_RUN |=> oe_q && !low_q) // [RULE_11]
      else $error("run code does not drive the pair");
   a_tri_pd: assert property (pair_code == PCSB_STATE_TRI_PD |=> !oe_q && pd_q) // [RULE_10]
      else $error("power-down state code not applied");
   a_tri_only: assert property (pair_code == PCSB_STATE_TRI && !byp_d // [RULE_10]
      |=> !oe_q && !pd_q)
      else $error("three-state code wrongly powers the loop down");
   a_state_b_low: assert property (regs_q[5][act_q] && def_b == PCSB_STATE_LOW // [RULE_14]
      |=> oe_q && low_q)
      else $error("definition b not applied");

   // Spread scale in quarter percent steps below the top code
   a_spread_scale: assert property (amt_q != 3'h7 |-> pct_q == {1'b0, amt_q}) // [RULE_02]
      else $error("spread not in quarter percent steps");
   a_off_zero: assert property (!mod_q |-> pct_q == 4'h0) // [RULE_02]
      else $error("spread amount shown while modulation is off");

   // Register bus: writes land only at a completing access, refused ones leave no trace
   a_write_access: assert property ($changed(regs_q[3]) |-> $past(wr_take)) // [RULE_04]
      else $error("frequency set byte changed outside a write");
   a_err_write: assert property (psel && penable && pready_q && pwrite && pslverr_q // [RULE_18]
      |=> $stable(spread_all))
      else $error("refused write changed a spread register");
   a_read_data: assert property (bus_q == PCSB_IDLE && psel && !penable && !pwrite // [RULE_17]
      && is_mapped(word_idx) |=> prdata_q == {24'h0, $past(regs_q[slot])})
      else $error("read data not from addressed register");

   // Routing and divider fields reach their outputs one edge later
   a_bypass_follow: assert property (##1 byp_q == $past(regs_q[4][PCSB_POS_BYPASS])) // [RULE_07]
      else $error("bypass bit not applied");
   a_first_src: assert property (##1 src1_q == $past(regs_q[4][PCSB_POS_FIRST_SRC])) // [RULE_08]
      else $error("first output source not applied");
   a_div4_follow: assert property (##1 div4_q == $past(regs_q[6][6:0])) // [RULE_19]
      else $error("divider four value not applied");
   a_div5_standby: assert property (run5_q == (div5_q != PCSB_DIV_STANDBY)) // [RULE_19]
      else $error("divider five standby flag wrong");
   a_div5_reserved: assert property (!regs_q[7][7]) // [RULE_19]
      else $error("reserved divider five bit set");

   c_write: cover property (wr_take && word_idx == PCSB_IDX_ROUTING);
   c_setting_change: cover property ($changed(act_q) && fsb_q);
   c_center_spread: cover property (ctr_q && mod_q);
   c_force_low: cover property (low_q);
   c_refused: cover property (psel && penable && pready_q && pslverr_q);
endmodule : pcsb_bank

// [logic/pcsb_pin_sync.sv]
`timescale 1ns/1ps
// ***********************************************************
// Three-stage pin synchroniser with agreement filter
// ***********************************************************
module pcsb_pin_sync import pcsb_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [2:0] pin_in,
   output logic [2:0] level_out
);
   logic [2:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;

   // New level accepted only once second and third stage agree
   always_comb begin
      lvl_d = lvl_q;
      for (int i = 0; i < 3; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            lvl_d[i] = s3_q[i];
         end
      end
   end

   // First stage feeds only the second stage, keeping metastability contained
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= 3'h0;
         s2_q <= 3'h0;
         s3_q <= 3'h0;
         lvl_q <= 3'h0;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= lvl_d;
      end
   end

   assign level_out = lvl_q;
endmodule : pcsb_pin_sync

// [logic/pcsb_pkg.sv]
package pcsb_pkg;
   // ***********************************************************
   // Register indices; byte address is four times the index
   // ***********************************************************
   localparam logic [9:0] PCSB_IDX_SPREAD_UPPER = 10'h020;
   localparam logic [9:0] PCSB_IDX_SPREAD_MIDDLE = 10'h021;
   localparam logic [9:0] PCSB_IDX_SPREAD_LOWER = 10'h022;
   localparam logic [9:0] PCSB_IDX_FREQ_SET = 10'h023;
   localparam logic [9:0] PCSB_IDX_ROUTING = 10'h024;
   localparam logic [9:0] PCSB_IDX_STATE_SEL = 10'h025;
   localparam logic [9:0] PCSB_IDX_DIR_DIV_FOUR = 10'h026;
   localparam logic [9:0] PCSB_IDX_DIV_FIVE = 10'h027;
   localparam int PCSB_NUM_REGS = 8;

   // ***********************************************************
   // Reset values
   // ***********************************************************
   localparam logic [7:0] PCSB_RST_SPREAD = 8'h00;
   localparam logic [7:0] PCSB_RST_FREQ_SET = 8'h00;
   localparam logic [7:0] PCSB_RST_ROUTING = 8'hed;
   localparam logic [7:0] PCSB_RST_STATE_SEL = 8'h02;
   localparam logic [7:0] PCSB_RST_DIR_DIV_FOUR = 8'h01;
   localparam logic [7:0] PCSB_RST_DIV_FIVE = 8'h01;

   // ***********************************************************
   // Field positions
   // ***********************************************************
   localparam int PCSB_POS_BYPASS = 7;
   localparam int PCSB_POS_FIRST_SRC = 6;
   localparam int PCSB_POS_SECOND_SRC = 4;
   localparam int PCSB_POS_STATE_DEF_B = 2;
   localparam int PCSB_POS_STATE_DEF_A = 0;
   localparam int PCSB_POS_DIRECTION = 7;
   localparam logic [7:0] PCSB_DIV_MASK = 8'h7f;

   // ***********************************************************
   // Codes
   // ***********************************************************
   localparam logic [2:0] PCSB_SPREAD_OFF = 3'h0;
   localparam logic [1:0] PCSB_STATE_TRI_PD = 2'h0;
   localparam logic [1:0] PCSB_STATE_TRI = 2'h1;
   localparam logic [1:0] PCSB_STATE_LOW = 2'h2;
   localparam logic [1:0] PCSB_STATE_RUN = 2'h3;
   localparam logic [6:0] PCSB_DIV_STANDBY = 7'h00;

   typedef enum {PCSB_IDLE, PCSB_ACCESS} pcsb_bus_type;
endpackage : pcsb_pkg
